// ### rtl/serial_control_regs.sv
/*
  Register bank for own bus address, soft sleep, reset pulses and CRC checker
  enable, shared by a local and a remote master.
  Assumes a front end that presents decoded byte accesses as structs and
  holds each request until its answer; strap levels are already digitised.
*/
`timescale 1ns/1ps
module serial_control_regs #(
  parameter logic [7:0] PULSE_CYCLES = scr_pkg::RESET_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Local master access
  input scr_pkg::reg_req_t local_req,
  output scr_pkg::reg_rsp_t local_rsp,
  // Remote master access through the control channel
  input scr_pkg::reg_req_t remote_req,
  output scr_pkg::reg_rsp_t remote_rsp,
  // Straps and link status
  input wire logic [2:0] address_strap_pin,
  input wire logic mode_strap_pin_zero,
  input wire logic bcc_link_detected,
  // Controls to the rest of the device
  output logic [6:0] own_bus_address,
  output logic power_down,
  output logic crc_checker_enable,
  output logic video_input_reset,
  output logic core_reset
);
  import scr_pkg::*;

  logic [1:0] grant;
  reg_req_t acc;
  strap_state_t state, next_state;
  logic [6:0] own_bus_address_field, next_own_bus_address_field;
  logic address_source_select, next_address_source_select;
  logic soft_sleep, next_soft_sleep;
  logic [7:0] gen_cfg, next_gen_cfg;
  logic [7:0] video_count, next_video_count;
  logic [7:0] core_count, next_core_count;
  logic full_reset_pending, next_full_reset_pending;
  reg_rsp_t next_local_rsp, next_remote_rsp;
  logic [6:0] next_own_bus_address;
  logic [7:0] rdata;
  logic wr;

  // ==========================================================================
  // Arbitration
  // Requests already answered are masked so a held valid is not served twice
  access_arbiter u_arb (
    .mclk(mclk),
    .reset(reset),
    .req({remote_req.valid & ~remote_rsp.done, local_req.valid & ~local_rsp.done}),
    .grant(grant)
  );

  assign acc = grant[1] ? remote_req : local_req;
  assign wr = (grant != 2'h0) && acc.write;

  // ==========================================================================
  // Read mux
  always_comb begin
    rdata = 8'h00;
    case (acc.addr)
      ADDR_BUS_ADDRESS_CONFIG: begin
        rdata = {own_bus_address_field, address_source_select};
      end
      ADDR_SLEEP_AND_RESET: begin
        rdata[BIT_SOFT_SLEEP] = soft_sleep;
        rdata[BIT_VIDEO_RESET] = video_count != 8'h00;
        rdata[BIT_FULL_CORE_RESET] = 1'b0;
        rdata[BIT_CORE_RESET_KEEP] = core_count != 8'h00;
      end
      ADDR_GENERAL_CONFIGURATION: begin
        rdata = gen_cfg;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  // ==========================================================================
  // Register state
  always_comb begin
    next_state = state;
    next_own_bus_address_field = own_bus_address_field;
    next_address_source_select = address_source_select;
    next_soft_sleep = soft_sleep;
    next_gen_cfg = gen_cfg;
    next_full_reset_pending = 1'b0;
    next_video_count = (video_count != 8'h00) ? video_count - 8'h01 : 8'h00;
    next_core_count = (core_count != 8'h00) ? core_count - 8'h01 : 8'h00;
    case (state)
      ST_LOAD_STRAPS: begin
        // Straps are caught one cycle after reset release, never under reset
        next_own_bus_address_field = strap_address(address_strap_pin);
        next_soft_sleep = mode_strap_pin_zero;
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (wr && acc.addr == ADDR_BUS_ADDRESS_CONFIG) begin
          next_own_bus_address_field = acc.wdata[7:1];
          next_address_source_select = acc.wdata[BIT_ADDRESS_SOURCE];
        end
        if (wr && acc.addr == ADDR_SLEEP_AND_RESET) begin
          next_soft_sleep = acc.wdata[BIT_SOFT_SLEEP];
          if (acc.wdata[BIT_VIDEO_RESET]) begin
            next_video_count = PULSE_CYCLES;
          end
          if (acc.wdata[BIT_CORE_RESET_KEEP]) begin
            next_core_count = PULSE_CYCLES;
          end
          if (acc.wdata[BIT_FULL_CORE_RESET]) begin
            next_core_count = PULSE_CYCLES;
            next_full_reset_pending = 1'b1;
          end
        end
        if (wr && acc.addr == ADDR_GENERAL_CONFIGURATION) begin
          next_gen_cfg = acc.wdata;
        end
        // Full core reset brings configuration back to defaults and re-reads straps
        if (full_reset_pending) begin
          next_address_source_select = 1'b0;
          next_gen_cfg = GENERAL_CONFIGURATION_RESET;
          next_state = ST_LOAD_STRAPS;
        end
      end
      default: begin
        next_state = ST_LOAD_STRAPS;
      end
    endcase
  end

  // ==========================================================================
  // Answers and outputs
  always_comb begin
    next_local_rsp = '0;
    next_remote_rsp = '0;
    next_local_rsp.done = grant[0];
    next_local_rsp.rdata = grant[0] ? rdata : 8'h00;
    next_remote_rsp.done = grant[1];
    next_remote_rsp.rdata = grant[1] ? rdata : 8'h00;
    // Strap address used unless software has selected its own field
    next_own_bus_address = next_address_source_select ? next_own_bus_address_field :
      strap_address(address_strap_pin);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_LOAD_STRAPS;
      own_bus_address_field <= STRAP_ADDRESS_BASE;
      address_source_select <= 1'b0;
      soft_sleep <= 1'b0;
      gen_cfg <= GENERAL_CONFIGURATION_RESET;
      video_count <= 8'h00;
      core_count <= 8'h00;
      full_reset_pending <= 1'b0;
      local_rsp <= '0;
      remote_rsp <= '0;
      own_bus_address <= STRAP_ADDRESS_BASE;
      power_down <= 1'b0;
      crc_checker_enable <= 1'b1;
      video_input_reset <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      state <= next_state;
      own_bus_address_field <= next_own_bus_address_field;
      address_source_select <= next_address_source_select;
      soft_sleep <= next_soft_sleep;
      gen_cfg <= next_gen_cfg;
      video_count <= next_video_count;
      core_count <= next_core_count;
      full_reset_pending <= next_full_reset_pending;
      local_rsp <= next_local_rsp;
      remote_rsp <= next_remote_rsp;
      own_bus_address <= next_own_bus_address;
      power_down <= next_soft_sleep & ~bcc_link_detected;
      crc_checker_enable <= next_gen_cfg[BIT_CRC_ENABLE];
      video_input_reset <= next_video_count != 8'h00;
      core_reset <= next_core_count != 8'h00;
    end
  end
endmodule

// ### rtl/scr_pkg.sv
/*
  Constants, field layout and carrier types for the serial control register
  bank (address, sleep/reset and general configuration registers).
  Assumes an external serial-bus front end that turns local and remote master
  traffic into the simple request/answer structs declared here.
*/
//
// Contract
// - Local and remote register accesses are arbitrated; each completes uncorrupted; a write granted in the strap reload after full core reset is dropped.
// - Address register bits 7:1 hold own bus address, defaulting to strap address.
// - Address bit 0 selects strap address (0) or programmed field (1).
// - Soft-sleep bit 7 set powers down while no back-channel link detected.
// - Soft-sleep bit loads from mode strap pin zero at power-up.
// - Writing bit 4 pulses video-input digital reset; bit self-clears.
// - Writing bit 1 resets whole core and configuration; self-clearing, reads zero.
// - Writing bit 0 resets core keeping configuration; self-clearing, reads one while core reset pulse lasts.
// - General configuration bit 7 enables CRC checker; register resets to 0xD2.
// - Strap level decodes to eight addresses, 0x0C to 0x1A, step two.
package scr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_BUS_ADDRESS_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_SLEEP_AND_RESET = 8'h01;
  localparam logic [7:0] ADDR_GENERAL_CONFIGURATION = 8'h03;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_ADDRESS_SOURCE = 0;
  localparam int unsigned BIT_SOFT_SLEEP = 7;
  localparam int unsigned BIT_VIDEO_RESET = 4;
  localparam int unsigned BIT_FULL_CORE_RESET = 1;
  localparam int unsigned BIT_CORE_RESET_KEEP = 0;
  localparam int unsigned BIT_CRC_ENABLE = 7;

  // ==========================================================================
  // Reset values and strap decode
  localparam logic [7:0] GENERAL_CONFIGURATION_RESET = 8'hD2;
  localparam logic [6:0] STRAP_ADDRESS_BASE = 7'h0C;
  localparam logic [7:0] RESET_PULSE_CYCLES = 8'h04;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } reg_rsp_t;

  typedef enum logic {
    ST_LOAD_STRAPS = 1'b0,
    ST_RUN = 1'b1
  } strap_state_t;

  // Eight strap levels map to addresses two apart
  function automatic logic [6:0] strap_address(input logic [2:0] level);
    strap_address = STRAP_ADDRESS_BASE + {3'h0, level, 1'b0};
  endfunction

endpackage

// ### rtl/access_arbiter.sv
/*
  Two-way round-robin arbiter granting one register access at a time.
  Assumes requesters hold their request until answered; grant is one cycle.
*/
`timescale 1ns/1ps
module access_arbiter (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Requests and grant, bit 0 local, bit 1 remote
  input wire logic [1:0] req,
  output logic [1:0] grant
);
  import scr_pkg::*;

  logic last_remote;
  logic [1:0] next_grant;
  logic next_last_remote;

  // ==========================================================================
  // Selection
  // A dead cycle after each grant lets the served side see its answer first
  always_comb begin
    next_grant = 2'h0;
    next_last_remote = last_remote;
    if (grant == 2'h0) begin
      if (req == 2'h3) begin
        next_grant = last_remote ? 2'h1 : 2'h2;
      end else begin
        next_grant = req;
      end
      if (next_grant != 2'h0) begin
        next_last_remote = next_grant[1];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      grant <= 2'h0;
      last_remote <= 1'b1;
    end else begin
      grant <= next_grant;
      last_remote <= next_last_remote;
    end
  end
endmodule

// ### verification/scr_props.sv
/*
  Port checker for the serial control register bank.
  Assumes it is bound into serial_control_regs, sharing PULSE_CYCLES.
*/
`timescale 1ns/1ps
module scr_props #(
  parameter logic [7:0] PULSE_CYCLES = 8'h04
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register accesses
  input scr_pkg::reg_req_t local_req,
  input scr_pkg::reg_rsp_t local_rsp,
  input scr_pkg::reg_req_t remote_req,
  input scr_pkg::reg_rsp_t remote_rsp,
  // Link and controls
  input wire logic bcc_link_detected,
  input wire logic power_down,
  input wire logic crc_checker_enable,
  input wire logic video_input_reset,
  input wire logic core_reset
);
  import scr_pkg::*;
  logic [7:0] vcnt;
  logic [7:0] ccnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Pulse widths counted, since a repetition cannot follow the parameter
  always_ff @(posedge mclk) begin
    vcnt <= video_input_reset ? vcnt + 8'h01 : 8'h00;
    ccnt <= core_reset ? ccnt + 8'h01 : 8'h00;
  end
  AST_CRC_RESET: assert property ($fell(reset) |-> crc_checker_enable)
    else $error("crc checker off after reset");
  AST_CRC_WRITE: assert property (local_rsp.done && local_req.write &&
    local_req.addr == ADDR_GENERAL_CONFIGURATION |-> crc_checker_enable == local_req.wdata[7])
    else $error("crc enable not written");
  AST_LOCAL_ANSWER: assert property ($rose(local_req.valid) |-> ##[2:4] local_rsp.done)
    else $error("local access unanswered");
  AST_REMOTE_ANSWER: assert property ($rose(remote_req.valid) |-> ##[2:4] remote_rsp.done)
    else $error("remote access unanswered");
  AST_DONE_SINGLE: assert property (local_rsp.done |=> !local_rsp.done)
    else $error("done longer than one cycle");
  AST_SLEEP_LINK: assert property ($past(bcc_link_detected) |-> !power_down)
    else $error("power down with link present");
  AST_VIDEO_PULSE: assert property ($fell(video_input_reset) |-> vcnt == PULSE_CYCLES)
    else $error("video reset pulse width");
  AST_CORE_PULSE: assert property ($fell(core_reset) |-> ccnt == PULSE_CYCLES)
    else $error("core reset pulse width");
  cover property (local_req.valid && remote_req.valid);
  cover property (power_down);
  cover property ($fell(core_reset));
endmodule
bind serial_control_regs scr_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_scr_props (
  .mclk(mclk), .reset(reset), .local_req(local_req), .local_rsp(local_rsp),
  .remote_req(remote_req), .remote_rsp(remote_rsp), .bcc_link_detected(bcc_link_detected),
  .power_down(power_down), .crc_checker_enable(crc_checker_enable),
  .video_input_reset(video_input_reset), .core_reset(core_reset));

// ### verification/reg_master.sv
/*
  Register master model for one side of the bank.
  Assumes the bench raises go only while idle.
*/
`timescale 1ns/1ps
module reg_master (
  // Clock
  input wire logic mclk,
  // Bench command: write, offset, data
  input wire logic go,
  input wire logic [16:0] cmd,
  output logic idle,
  output logic [7:0] rdata,
  // Bank port
  input scr_pkg::reg_rsp_t rsp,
  output scr_pkg::reg_req_t req
);
  initial begin
    req = '0;
    idle = 1'b1;
    rdata = 8'h00;
  end
  // One access in flight; released lines show inverted values, not stale ones
  always @(posedge mclk) begin
    if (req.valid && rsp.done) begin
      req <= {1'b0, ~req[16:0]};
      rdata <= rsp.rdata;
      idle <= 1'b1;
    end else if (go && idle) begin
      req <= {1'b1, cmd};
      idle <= 1'b0;
    end
  end
endmodule

// ### verification/serial_control_regs_tb.sv
/*
  Self-checking bench for serial_control_regs, local and remote masters.
  Assumes the checker and master model files compile before it.
*/
`timescale 1ns/1ps
module serial_control_regs_tb;
  import scr_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] strap = 3'h5;
  logic mode = 1'b1;
  logic link = 1'b0;
  logic [1:0] go = 2'b00;
  logic [1:0] idle;
  logic [16:0] cmd [2];
  logic [7:0] rdata [2];
  reg_req_t req [2];
  reg_rsp_t rsp [2];
  logic [6:0] own_addr;
  logic pd;
  logic crc;
  logic vrst;
  logic crst;
  logic [31:0] seed = 32'h00001D75;
  logic [7:0] v;
  int fails = 0;
  int total_checks = 0;
  always #12.5 mclk = ~mclk;
  serial_control_regs i_serial_control_regs (.mclk(mclk), .reset(reset),
    .local_req(req[0]), .local_rsp(rsp[0]), .remote_req(req[1]), .remote_rsp(rsp[1]),
    .address_strap_pin(strap), .mode_strap_pin_zero(mode), .bcc_link_detected(link),
    .own_bus_address(own_addr), .power_down(pd), .crc_checker_enable(crc),
    .video_input_reset(vrst), .core_reset(crst));
  for (genvar g = 0; g < 2; g++) begin : gm
    reg_master i_reg_master (.mclk(mclk), .go(go[g]), .cmd(cmd[g]), .idle(idle[g]),
      .rdata(rdata[g]), .rsp(rsp[g]), .req(req[g]));
  end
  // ==========================================================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] sa(input logic [2:0] l);
    return {7'h0C + {3'h0, l, 1'b0}, 1'b0};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [1:0] m);
    int n;
    n = 0;
    @(posedge mclk) go <= m;
    @(posedge mclk) go <= 2'b00;
    #1;
    while (idle !== 2'b11 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    if (idle !== 2'b11) begin
      fails++;
      $display("CHECK FAILED %0t wait limit reached", $time);
      stop_test();
    end
  endtask
  task automatic acc(input int m, input logic w, input logic [7:0] a, input logic [7:0] d);
    cmd[m] = {w, a, d};
    run(m == 0 ? 2'b01 : 2'b10);
    if (!w) chk(rdata[m], d);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    wait_cyc(5);
    reset <= 1'b0;
    wait_cyc(3);
    acc(0, 0, ADDR_GENERAL_CONFIGURATION, 8'hD2);
    acc(1, 0, ADDR_BUS_ADDRESS_CONFIG, sa(strap));
    acc(0, 0, ADDR_SLEEP_AND_RESET, {mode, 7'h00});
    for (int l = 0; l < 8; l++) begin
      @(posedge mclk) strap <= 3'(l);
      wait_cyc(3);
      chk({own_addr, 1'b0}, sa(3'(l)));
    end
    v = rnd() | 8'h01;
    acc(0, 1, ADDR_BUS_ADDRESS_CONFIG, v);
    chk({own_addr, 1'b1}, v);
    acc(1, 1, ADDR_BUS_ADDRESS_CONFIG, v & 8'hFE);
    chk({own_addr, 1'b0}, sa(strap));
    acc(0, 1, 8'h02, rnd());
    acc(1, 0, 8'h02, 8'h00);
    acc(0, 1, ADDR_SLEEP_AND_RESET, 8'hEC);
    wait_cyc(2);
    chk({7'h00, pd}, 8'h01);
    acc(1, 0, ADDR_SLEEP_AND_RESET, 8'h80);
    @(posedge mclk) link <= 1'b1;
    wait_cyc(2);
    chk({7'h00, pd}, 8'h00);
    // Soft sleep kept set so the later read still expects bit 7
    acc(0, 1, ADDR_SLEEP_AND_RESET, 8'h90);
    chk({7'h00, vrst}, 8'h01);
    wait_cyc(6);
    acc(1, 0, ADDR_SLEEP_AND_RESET, 8'h80);
    acc(1, 1, ADDR_GENERAL_CONFIGURATION, 8'h00);
    chk({7'h00, crc}, 8'h00);
    acc(0, 1, ADDR_SLEEP_AND_RESET, 8'h81);
    chk({7'h00, crst}, 8'h01);
    wait_cyc(10);
    acc(0, 0, ADDR_GENERAL_CONFIGURATION, 8'h00);
    acc(0, 1, ADDR_BUS_ADDRESS_CONFIG, 8'h01);
    acc(1, 1, ADDR_SLEEP_AND_RESET, 8'h02);
    chk({7'h00, crst}, 8'h01);
    wait_cyc(10);
    acc(1, 0, ADDR_GENERAL_CONFIGURATION, 8'hD2);
    chk({7'h00, crc}, 8'h01);
    acc(0, 0, ADDR_BUS_ADDRESS_CONFIG, sa(strap));
    acc(0, 0, ADDR_SLEEP_AND_RESET, {mode, 7'h00});
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      cmd[0] = {1'b1, ADDR_GENERAL_CONFIGURATION, v};
      cmd[1] = {1'b1, ADDR_BUS_ADDRESS_CONFIG, v & 8'hFE};
      run(2'b11);
      cmd[0] = {1'b0, ADDR_BUS_ADDRESS_CONFIG, 8'h00};
      cmd[1] = {1'b0, ADDR_GENERAL_CONFIGURATION, 8'h00};
      run(2'b11);
      chk(rdata[0], v & 8'hFE);
      chk(rdata[1], v);
    end
    stop_test();
  end
endmodule
